// *** design/pam_port_a.sv ***
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps

// Functional notes
// - Eight-bit output latch, reset zero, drives outputs
// - Latch reaches pin only in general-purpose function
// - Pin-state read of output bit returns latch
// - Pin-state read of input bit returns pin
// - Pin-state register ignores writes
// - Pin-state has no reset, follows pins
// - Pull-up bit 1 enables pull-up, resets zero
// - Pull-up forced off whenever pin is output
// - Modes 1,2,5,6 honour only bits 7-5, except open-drain bits 4-0
// - Open-drain bit 1: drive low, release high
// - Open-drain bit 0: push-pull, resets zero
// - Direction 1, enable 1: pin drives address
// - Direction 1, enable 0: pin drives latch
// - Enable bit n maps pin n, address 16+n
// - Address enables read/write, reset all ones
// - Write-only direction register, reset zero
// - Modes 1,2,5,6: pins 4-0 always address
// - Mode 7 without expansion: plain I/O only

module pam_port_a
   import pam_pkg::*;
#(
   parameter int PW = `PAM_PORT_W
) (
   input wire logic i_clk_sys, // System clock, 100 MHz
   input wire logic i_srst, // Synchronous reset, active high
   input wire logic i_clk_en, // Freezes all state when low
   input wire pam_apb_req_t i_apb, // APB request
   output pam_apb_rsp_t o_apb, // APB answer
   input wire logic [2:0] i_op_mode, // Operating mode from mode logic
   input wire logic i_external_expansion_enable, // Expansion enable for mode 7
   input wire logic [PW-1:0] i_addr_hi, // Address bits 23 to 16
   input wire logic [PW-1:0] i_pin_in, // Pin levels, asynchronous
   output logic [PW-1:0] o_pin_out, // Pin output value
   output logic [PW-1:0] o_pin_oe, // Pin output enable, high drives
   output logic [PW-1:0] o_pullup_en // Input pull-up enable
);

   pam_reg_t sel;
   logic wr_en;
   logic [`PAM_DATA_W-1:0] wdata;
   logic [`PAM_DATA_W-1:0] rdata;
   logic [PW-1:0] pin_sync;

   logic [PW-1:0] direction_reg;
   logic [PW-1:0] direction_next;
   logic [PW-1:0] port_output_latch_reg;
   logic [PW-1:0] port_output_latch_next;
   logic [PW-1:0] port_pullup_control_reg;
   logic [PW-1:0] port_pullup_control_next;
   logic [PW-1:0] port_open_drain_control_reg;
   logic [PW-1:0] port_open_drain_control_next;
   logic [PW-1:0] address_output_enable_reg;
   logic [PW-1:0] address_output_enable_next;
   logic [PW-1:0] port_pin_state;

   logic [PW-1:0] pin_out_next;
   logic [PW-1:0] pin_oe_next;
   logic [PW-1:0] pullup_next;

   // True in the modes where only the top three pins are ports
   function automatic logic low_pins_fixed(input logic [2:0] mode);
      return (mode == `PAM_MODE_1) || (mode == `PAM_MODE_2) ||
         (mode == `PAM_MODE_5) || (mode == `PAM_MODE_6);
   endfunction

   // Pin function from mode, expansion enable, direction and address enable
   function automatic pam_pin_func_t pin_func(input logic [2:0] mode, input logic external_expansion_enable,
      input int idx, input logic dir, input logic aen);
      pam_pin_func_t f;
      f = dir ? PAM_PF_GPO : PAM_PF_INPUT;
      if (low_pins_fixed(mode)) begin
         if (idx < `PAM_LOW_PINS) begin
            f = PAM_PF_ADDR;
         end else if (dir && aen) begin
            f = PAM_PF_ADDR;
         end
      end else if ((mode == `PAM_MODE_4) || ((mode == `PAM_MODE_7) && external_expansion_enable)) begin
         if (dir && aen) begin
            f = PAM_PF_ADDR;
         end
      end
      // Mode 7 without expansion, and unlisted modes, keep plain I/O
      return f;
   endfunction

   pam_apb_slave u_apb_slave (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_clk_en(i_clk_en),
      .i_apb(i_apb),
      .o_apb(o_apb),
      .o_sel(sel),
      .o_wr_en(wr_en),
      .o_wdata(wdata),
      .i_rdata(rdata)
   );

   pam_pin_sync #(
      .W(PW)
   ) u_pin_sync (
      .i_clk_sys(i_clk_sys),
      .i_clk_en(i_clk_en),
      .i_async(i_pin_in),
      .o_sync(pin_sync)
   );

   // Next values of the software registers
   always_comb begin
      direction_next = direction_reg;
      port_output_latch_next = port_output_latch_reg;
      port_pullup_control_next = port_pullup_control_reg;
      port_open_drain_control_next = port_open_drain_control_reg;
      address_output_enable_next = address_output_enable_reg;
      if (wr_en) begin
         case (sel)
            PAM_REG_DIRECTION: direction_next = wdata[PW-1:0];
            PAM_REG_LATCH: port_output_latch_next = wdata[PW-1:0];
            PAM_REG_PULLUP: port_pullup_control_next = wdata[PW-1:0];
            PAM_REG_OPEN_DRAIN: port_open_drain_control_next = wdata[PW-1:0];
            PAM_REG_ADDR_ENABLE: address_output_enable_next = wdata[PW-1:0];
            PAM_REG_PIN_STATE: ; // Read-only, write dropped
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         direction_reg <= `PAM_RST_DIRECTION;
      end else if (i_clk_en) begin
         direction_reg <= direction_next;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         port_output_latch_reg <= `PAM_RST_LATCH;
      end else if (i_clk_en) begin
         port_output_latch_reg <= port_output_latch_next;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         port_pullup_control_reg <= `PAM_RST_PULLUP;
      end else if (i_clk_en) begin
         port_pullup_control_reg <= port_pullup_control_next;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         port_open_drain_control_reg <= `PAM_RST_OPEN_DRAIN;
      end else if (i_clk_en) begin
         port_open_drain_control_reg <= port_open_drain_control_next;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         address_output_enable_reg <= `PAM_RST_ADDR_ENABLE;
      end else if (i_clk_en) begin
         address_output_enable_reg <= address_output_enable_next;
      end
   end

   // Per-pin function, drive and pull-up, from the next register values
   generate
      for (genvar n = 0; n < PW; n++) begin : g_pin
         pam_pin_func_t func;
         logic drive_val;
         assign func = pin_func(i_op_mode, i_external_expansion_enable, n,
            direction_next[n], address_output_enable_next[n]);
         // Address line 16+n or the latch, never both
         assign drive_val = (func == PAM_PF_ADDR) ? i_addr_hi[n] : port_output_latch_next[n];
         assign pin_out_next[n] = drive_val;
         // Open drain releases the pin for a one
         assign pin_oe_next[n] = (func != PAM_PF_INPUT) &
            ~(port_open_drain_control_next[n] & drive_val);
         // Pull-up only on an input port
         assign pullup_next[n] = (func == PAM_PF_INPUT) & port_pullup_control_next[n] &
            ~(low_pins_fixed(i_op_mode) && (n < `PAM_LOW_PINS));
         // Output bits read the latch, inputs the pin
         assign port_pin_state[n] = direction_reg[n] ? port_output_latch_reg[n] : pin_sync[n];
      end
   endgenerate

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_pin_out <= `PAM_RST_LATCH;
         o_pin_oe <= `PAM_RST_DIRECTION;
         o_pullup_en <= `PAM_RST_PULLUP;
      end else if (i_clk_en) begin
         o_pin_out <= pin_out_next;
         o_pin_oe <= pin_oe_next;
         o_pullup_en <= pullup_next;
      end
   end

   // Read multiplexer; direction reads back as zero
   always_comb begin
      rdata = `PAM_READ_ZERO;
      case (sel)
         PAM_REG_LATCH: rdata[PW-1:0] = port_output_latch_reg;
         PAM_REG_PIN_STATE: rdata[PW-1:0] = port_pin_state;
         PAM_REG_PULLUP: rdata[PW-1:0] = port_pullup_control_reg;
         PAM_REG_OPEN_DRAIN: rdata[PW-1:0] = port_open_drain_control_reg;
         PAM_REG_ADDR_ENABLE: rdata[PW-1:0] = address_output_enable_reg;
         PAM_REG_DIRECTION: rdata = `PAM_READ_ZERO;
         default: rdata = `PAM_READ_ZERO;
      endcase
   end

endmodule // pam_port_a

// *** design/pam_cfg.svh ***
`ifndef PAM_CFG_SVH
`define PAM_CFG_SVH

// Port geometry
`define PAM_PORT_W 8
`define PAM_DATA_W 32
`define PAM_ADDR_W 32
`define PAM_ADDR_LSB 2
`define PAM_IDX_W 3
`define PAM_LOW_PINS 5

// Register byte offsets
`define PAM_OFF_DIRECTION 32'h0000_0000
`define PAM_OFF_LATCH 32'h0000_0004
`define PAM_OFF_PIN_STATE 32'h0000_0008
`define PAM_OFF_PULLUP 32'h0000_000C
`define PAM_OFF_OPEN_DRAIN 32'h0000_0010
`define PAM_OFF_ADDR_ENABLE 32'h0000_0014

// Reset values
`define PAM_RST_DIRECTION 8'h00
`define PAM_RST_LATCH 8'h00
`define PAM_RST_PULLUP 8'h00
`define PAM_RST_OPEN_DRAIN 8'h00
`define PAM_RST_ADDR_ENABLE 8'hFF
`define PAM_RST_RDATA 32'h0000_0000
`define PAM_READ_ZERO 32'h0000_0000

// Operating modes
`define PAM_MODE_1 3'h1
`define PAM_MODE_2 3'h2
`define PAM_MODE_4 3'h4
`define PAM_MODE_5 3'h5
`define PAM_MODE_6 3'h6
`define PAM_MODE_7 3'h7

`endif

// *** design/pam_pkg.sv ***
`include "pam_cfg.svh"

package pam_pkg;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [`PAM_ADDR_W-1:0] paddr;
      logic [`PAM_DATA_W-1:0] pwdata;
   } pam_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [`PAM_DATA_W-1:0] prdata;
   } pam_apb_rsp_t;

   typedef enum logic [2:0] {
      PAM_REG_DIRECTION = 3'h0,
      PAM_REG_LATCH = 3'h1,
      PAM_REG_PIN_STATE = 3'h3,
      PAM_REG_PULLUP = 3'h2,
      PAM_REG_OPEN_DRAIN = 3'h6,
      PAM_REG_ADDR_ENABLE = 3'h7,
      PAM_REG_NONE = 3'h5
   } pam_reg_t;

   typedef enum logic [1:0] {
      PAM_PF_INPUT = 2'h0,
      PAM_PF_GPO = 2'h1,
      PAM_PF_ADDR = 2'h3
   } pam_pin_func_t;

   function automatic pam_reg_t pam_decode(input logic [`PAM_ADDR_W-1:0] addr);
      pam_reg_t sel;
      case (addr)
         `PAM_OFF_DIRECTION: sel = PAM_REG_DIRECTION;
         `PAM_OFF_LATCH: sel = PAM_REG_LATCH;
         `PAM_OFF_PIN_STATE: sel = PAM_REG_PIN_STATE;
         `PAM_OFF_PULLUP: sel = PAM_REG_PULLUP;
         `PAM_OFF_OPEN_DRAIN: sel = PAM_REG_OPEN_DRAIN;
         `PAM_OFF_ADDR_ENABLE: sel = PAM_REG_ADDR_ENABLE;
         default: sel = PAM_REG_NONE;
      endcase
      return sel;
   endfunction

endpackage

// *** design/pam_pin_sync.sv ***
`timescale 1ns/1ps

module pam_pin_sync
   import pam_pkg::*;
#(
   parameter int W = `PAM_PORT_W
) (
   input wire logic i_clk_sys, // System clock
   input wire logic i_clk_en, // Freezes the chain when low
   input wire logic [W-1:0] i_async, // Raw pin levels
   output logic [W-1:0] o_sync // Levels after two stages
);

   logic [W-1:0] meta_reg;

   // No reset: the chain follows the pin level, two cycles late, while the clock enable is high
   always_ff @(posedge i_clk_sys) begin
      if (i_clk_en) begin
         meta_reg <= i_async;
         o_sync <= meta_reg;
      end
   end

endmodule // pam_pin_sync

// *** design/pam_apb_slave.sv ***
`timescale 1ns/1ps

module pam_apb_slave
   import pam_pkg::*;
(
   input wire logic i_clk_sys, // System clock
   input wire logic i_srst, // Synchronous reset, active high
   input wire logic i_clk_en, // Freezes state when low
   input wire pam_apb_req_t i_apb, // APB request
   output pam_apb_rsp_t o_apb, // APB answer, registered
   output pam_reg_t o_sel, // Decoded register
   output logic o_wr_en, // Write commit strobe
   output logic [`PAM_DATA_W-1:0] o_wdata, // Write data
   input wire logic [`PAM_DATA_W-1:0] i_rdata // Read value of o_sel
);

   logic setup;

   assign o_sel = pam_decode(i_apb.paddr);
   assign setup = i_apb.psel & ~i_apb.penable;
   assign o_wdata = i_apb.pwdata;
   // Commit on the edge that completes the access phase
   assign o_wr_en = i_apb.psel & i_apb.penable & o_apb.pready & i_apb.pwrite &
      (o_sel != PAM_REG_NONE) & i_clk_en;

   // Answer is prepared in the setup cycle: no wait states
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_apb.pready <= 1'b0;
         o_apb.pslverr <= 1'b0;
         o_apb.prdata <= `PAM_RST_RDATA;
      end else if (i_clk_en) begin
         o_apb.pready <= setup;
         o_apb.pslverr <= setup & (o_sel == PAM_REG_NONE);
         o_apb.prdata <= (setup & ~i_apb.pwrite) ? i_rdata : `PAM_READ_ZERO;
      end
   end

endmodule // pam_apb_slave

// *** verification/pam_pin_model.sv ***
`timescale 1ns/1ps

module pam_pin_model (
   input wire logic i_clk_sys, // Clock
   input wire logic [7:0] i_out, // Device value
   input wire logic [7:0] i_oe, // Device drives
   input wire logic [7:0] i_pu, // Pull-up on
   input wire logic [7:0] i_ext, // Far-side value
   input wire logic [7:0] i_ext_en, // Far side drives
   output logic [7:0] o_level // Resolved level
);
   logic [7:0] float_reg = 8'h00;
   // Undriven wire wanders
   always_ff @(posedge i_clk_sys) begin
      float_reg <= ~float_reg;
   end
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         if (i_oe[b]) begin
            o_level[b] = i_out[b];
         end else if (i_ext_en[b]) begin
            o_level[b] = i_ext[b];
         end else if (i_pu[b]) begin
            o_level[b] = 1'b1;
         end else begin
            o_level[b] = float_reg[b];
         end
      end
   end
endmodule // pam_pin_model

// *** verification/pam_port_a_chk.sv ***
`timescale 1ns/1ps

module pam_port_a_chk
   import pam_pkg::*;
#(
   parameter int PW = 8
) (
   input wire logic i_clk_sys, // Clock
   input wire logic i_srst, // Reset
   input wire logic i_clk_en, // Enable
   input wire pam_apb_req_t i_apb, // Request
   input wire pam_apb_rsp_t o_apb, // Answer
   input wire logic [2:0] i_op_mode, // Mode
   input wire logic [PW-1:0] i_addr_hi, // Address
   input wire logic [PW-1:0] o_pin_out, // Pin value
   input wire logic [PW-1:0] o_pin_oe, // Pin enable
   input wire logic [PW-1:0] o_pullup_en // Pull-up
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   wire setup = i_apb.psel && !i_apb.penable && i_clk_en;
   wire mapped = (i_apb.paddr <= 32'h0000_0014) && (i_apb.paddr[1:0] == 2'h0);
   wire narrow = i_op_mode inside {3'h1, 3'h2, 3'h5, 3'h6};

   a_ready_after_setup: assert property (setup |=> o_apb.pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (o_apb.pready && i_clk_en |=> !o_apb.pready)
      else $error("ready stood too long");
   a_unmapped_error: assert property (setup && !mapped |=> o_apb.pslverr)
      else $error("unmapped access not refused");
   a_mapped_no_error: assert property (setup && mapped |=>
      !o_apb.pslverr && (i_apb.pwrite || o_apb.prdata[31:8] == 24'h0))
      else $error("mapped access refused");
   a_reset_outputs: assert property ($fell(i_srst) |->
      o_pin_out == '0 && o_pin_oe == '0 && o_pullup_en == '0)
      else $error("pins active out of reset");
   a_pullup_input_only: assert property ((o_pullup_en & o_pin_oe) == '0)
      else $error("pull-up on a driven pin");
   a_low_pins_address: assert property (i_clk_en && narrow |=>
      o_pin_out[4:0] == $past(i_addr_hi[4:0]))
      else $error("low pins not address");
   a_low_pins_pullup: assert property (i_clk_en && narrow |=> o_pullup_en[4:0] == 5'h00)
      else $error("low pin pull-up on");
endmodule // pam_port_a_chk

bind pam_port_a pam_port_a_chk #(.PW(PW)) u_chk (.i_clk_sys, .i_srst, .i_clk_en, .i_apb, .o_apb,
   .i_op_mode, .i_addr_hi, .o_pin_out, .o_pin_oe, .o_pullup_en);

// *** verification/testbench.sv ***
`timescale 1ns/1ps

module testbench
   import pam_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic en = 1'b1;
   logic exp_en = 1'b0;
   logic [2:0] mode = 3'h7;
   logic [7:0] addr_hi = 8'h00;
   logic [7:0] ext_en = 8'hFF;
   logic [7:0] pins, pout, poe, ppu;
   pam_apb_req_t apb = '0;
   pam_apb_rsp_t rsp;
   int failures = 0;
   int num_checks = 0;
   logic [31:0] rd;
   logic err;
   logic [31:0] offs [5] = '{32'h0000_0000, 32'h0000_0004, 32'h0000_000C, 32'h0000_0010, 32'h0000_0014};
   logic [7:0] rstv [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};

   initial begin
      forever #5 clk = ~clk;
   end

   pam_port_a dut (.i_clk_sys(clk), .i_srst(srst), .i_clk_en(en), .i_apb(apb), .o_apb(rsp),
      .i_op_mode(mode), .i_external_expansion_enable(exp_en), .i_addr_hi(addr_hi),
      .i_pin_in(pins), .o_pin_out(pout), .o_pin_oe(poe), .o_pullup_en(ppu));
   pam_pin_model u_pins (.i_clk_sys(clk), .i_out(pout), .i_oe(poe), .i_pu(ppu), .i_ext(8'h5A),
      .i_ext_en(ext_en), .o_level(pins));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      apb <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      apb.penable <= 1'b1;
      // Ready, data and error are taken at the rising edge that completes the access
      do begin
         @(posedge clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (rsp.pready !== 1'b1) begin
         failures++;
         results();
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [7:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk(rd, {24'h00_0000, exp});
   endtask

   task automatic cfg(input logic [7:0] dr, lt, pu, od, ae);
      xfer(1'b1, offs[0], {24'h00_0000, dr});
      xfer(1'b1, offs[1], {24'h00_0000, lt});
      xfer(1'b1, offs[2], {24'h00_0000, pu});
      xfer(1'b1, offs[3], {24'h00_0000, od});
      xfer(1'b1, offs[4], {24'h00_0000, ae});
      repeat (3) @(negedge clk);
   endtask

   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      rdchk(32'h0000_0008, 8'h5A);
      foreach (offs[i]) rdchk(offs[i], rstv[i]);
      foreach (offs[i]) begin
         xfer(1'b1, offs[i], 32'hFFFF_FF3C);
         rdchk(offs[i], (i == 0) ? 8'h00 : 8'h3C);
      end
      ext_en <= 8'h00;
      cfg(8'hF0, 8'hA5, 8'hFF, 8'h00, 8'hFF);
      chk(poe, 8'hF0);
      chk(pout & poe, 8'hA0);
      chk(ppu, 8'h0F);
      rdchk(32'h0000_0008, 8'hAF);
      xfer(1'b1, 32'h0000_0008, 32'h0000_0000);
      rdchk(32'h0000_0004, 8'hA5);
      rdchk(32'h0000_0008, 8'hAF);
      xfer(1'b1, offs[3], 32'h0000_00FF);
      repeat (3) @(negedge clk);
      chk(poe, 8'h50);
      @(posedge clk);
      mode <= 3'h4;
      addr_hi <= 8'h69;
      cfg(8'hFF, 8'hA5, 8'hFF, 8'h00, 8'h0F);
      chk(poe, 8'hFF);
      chk(pout, 8'hA9);
      chk(ppu, 8'h00);
      @(posedge clk);
      mode <= 3'h1;
      cfg(8'h00, 8'hA5, 8'hFF, 8'h00, 8'hFF);
      chk(poe, 8'h1F);
      chk(pout & poe, 8'h09);
      chk(ppu, 8'hE0);
      @(posedge clk);
      mode <= 3'h7;
      exp_en <= 1'b1;
      cfg(8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF);
      chk(pout, 8'h69);
      @(posedge clk);
      addr_hi <= 8'h96;
      repeat (3) @(negedge clk);
      chk(pout, 8'h96);
      // Clock enable low freezes the pins; they catch up once it returns
      @(posedge clk);
      en <= 1'b0;
      addr_hi <= 8'h3C;
      repeat (3) @(negedge clk);
      chk(pout, 8'h96);
      @(posedge clk);
      en <= 1'b1;
      repeat (3) @(negedge clk);
      chk(pout, 8'h3C);
      xfer(1'b1, 32'h0000_0018, 32'h0000_00FF);
      chk(err, 1'b1);
      xfer(1'b0, 32'h0000_0002, 32'h0000_0000);
      chk(err, 1'b1);
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rdchk(offs[1], 8'h00);
      rdchk(offs[4], 8'hFF);
      results();
   end
endmodule // testbench
